// >>> rpso_consts.vh
// Purpose: constants for the rtp delay-variation slip offset control block
// Assumes: 32-bit classic wishbone register bus, byte addresses
// Notes: all offsets are byte addresses of aligned words
`ifndef RPSO_CONSTS_VH
`define RPSO_CONSTS_VH

`define RPSO_ADR_CTRL 8'h00
`define RPSO_ADR_TARGET 8'h04
`define RPSO_ADR_REMOTE 8'h08
`define RPSO_ADR_SLIP 8'h0C
`define RPSO_ADR_LOCAL 8'h10
`define RPSO_ADR_MINLEAD 8'h14
`define RPSO_ADR_INITLEAD 8'h18

`define RPSO_BIT_ONCE 0
`define RPSO_BIT_SILENCE 1
`define RPSO_BIT_MARKER 2
`define RPSO_BIT_INITLEAD 3
`define RPSO_BIT_SEEN 4
`define RPSO_BIT_BLKINC 5
`define RPSO_BIT_BLKDEC 6
`define RPSO_BIT_ALWAYS 7
`define RPSO_THR_LSB 8
`define RPSO_THR_MSB 10

`define RPSO_SIL_BASE_LOG2 4
`define RPSO_CTRL_RESET 32'h0000_0000
`define RPSO_DATA_RESET 32'h0000_0000
`define RPSO_ERR_DATA 32'h0000_0000

`endif

// >>> rpso_silence_thr.v
// Purpose: silence threshold decode, 16 times two to the field value
// Assumes: field is 3 bits
// Notes: combinational, maps 000 to 16 frames and 111 to 2048 frames
`include "rpso_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module rpso_silence_thr (
    input wire [2:0] thrSel,
    output reg [31:0] thrFrames
);
    // shift of a single one, threshold is a power of two
    // sum kept 4 bits wide, a 3-bit sum would wrap from field 100 upward
    always @* begin
        thrFrames = 32'h0000_0001 << ({1'b0, thrSel} + 4'd`RPSO_SIL_BASE_LOG2);
    end
endmodule // rpso_silence_thr

`default_nettype wire

// >>> rpso_slip_ctrl.v
// Purpose: per-connection slip offset bookkeeping for received rtp voice packets
// Assumes: packet logic gives one-cycle pkt strobe with stamps, marker and slip event
// Notes: one connection structure held in registers reached over classic wishbone
//
// Summary of operation
// - once-reset bit zeroes slip count at next packet, then self-clears
// - silence-reset bit zeroes count after long gap, then self-clears
// - marker-reset bit zeroes count on next marked packet, then self-clears
// - silence threshold is 16 frames times two to the 3-bit field
// - init-with-lead loads count with minimum delay plus initial lead on first packet
// - without init-with-lead the target difference is trusted, normal slipping
// - hardware sets first-packet flag after the first packet
// - last remote timestamp stored from rtp stamp when rtp present
// - without rtp remote timestamp advances by frames in packet
// - signed slip count, overruns up, underruns down
// - playout difference is target plus slip count
// - difference is remote stamp minus local bus stamp
// - block-increment bit freezes count on overruns
// - block-decrement bit freezes count on underruns
// - always-reset bit zeroes count on every packet except an init-with-lead first packet
// - local bus stamp at last packet is recorded
//
// Our own choices: register access over Wishbone and the register offsets.
`include "rpso_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module rpso_slip_ctrl (
    input wire clk_sys,
    input wire rst,
    // classic wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // packet side, same clock domain
    input wire pktValid,
    input wire pktRtp,
    input wire pktMarker,
    input wire [31:0] pktRemoteStamp,
    input wire [7:0] pktFrames,
    input wire [31:0] localBusStamp,
    input wire pktOverrun,
    input wire pktUnderrun,
    input wire [15:0] pktSlipFrames,
    // results
    output reg [31:0] playDelta,
    output reg [31:0] arrivalDelta,
    output reg pktDone,
    output reg slipEvent
);
    reg [31:0] ctrl_reg;
    reg [31:0] target_reg;
    reg [31:0] remote_reg;
    reg [31:0] slip_reg;
    reg [31:0] local_reg;
    reg [31:0] minLead_reg;
    reg [31:0] initLead_reg;
    reg [31:0] ctrl_next;
    reg [31:0] slip_next;
    reg [31:0] remote_next;
    reg [31:0] expRemote;
    reg [31:0] gapFrames;
    reg doReset;
    reg hitOnce;
    reg hitSilence;
    reg hitMarker;
    wire [31:0] thrFrames;
    wire wbReq;
    wire wbAddrOk;
    wire [31:0] byteMask;

    assign wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign wbAddrOk = (wb_adr_i == `RPSO_ADR_CTRL) || (wb_adr_i == `RPSO_ADR_TARGET) ||
        (wb_adr_i == `RPSO_ADR_REMOTE) || (wb_adr_i == `RPSO_ADR_SLIP) ||
        (wb_adr_i == `RPSO_ADR_LOCAL) || (wb_adr_i == `RPSO_ADR_MINLEAD) ||
        (wb_adr_i == `RPSO_ADR_INITLEAD);
    assign byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    rpso_silence_thr uThr (
        .thrSel(ctrl_reg[`RPSO_THR_MSB:`RPSO_THR_LSB]),
        .thrFrames(thrFrames)
    );

    // per-packet update of the structure
    always @* begin
        ctrl_next = ctrl_reg;
        slip_next = slip_reg;
        remote_next = remote_reg;
        expRemote = remote_reg + {24'h00_0000, pktFrames};
        // gap measured as frames since the last stored remote stamp
        gapFrames = pktRemoteStamp - remote_reg;
        hitOnce = ctrl_reg[`RPSO_BIT_ONCE];
        hitSilence = ctrl_reg[`RPSO_BIT_SILENCE] && pktRtp &&
            ctrl_reg[`RPSO_BIT_SEEN] && !gapFrames[31] && (gapFrames >= thrFrames);
        hitMarker = ctrl_reg[`RPSO_BIT_MARKER] && pktRtp && pktMarker;
        doReset = hitOnce || hitSilence || hitMarker || ctrl_reg[`RPSO_BIT_ALWAYS];
        if (pktValid) begin
            // stored sender stamp, emulated when no rtp header
            remote_next = pktRtp ? pktRemoteStamp : expRemote;
            if (!ctrl_reg[`RPSO_BIT_SEEN] && ctrl_reg[`RPSO_BIT_INITLEAD]) begin
                slip_next = minLead_reg + initLead_reg;
            end else if (doReset) begin
                slip_next = 32'h0000_0000;
            end else if (pktOverrun && !ctrl_reg[`RPSO_BIT_BLKINC]) begin
                slip_next = slip_reg + {16'h0000, pktSlipFrames};
            end else if (pktUnderrun && !ctrl_reg[`RPSO_BIT_BLKDEC]) begin
                slip_next = slip_reg - {16'h0000, pktSlipFrames};
            end
            // satisfied requests all drop in the same update
            if (hitOnce) ctrl_next[`RPSO_BIT_ONCE] = 1'b0;
            if (hitSilence) ctrl_next[`RPSO_BIT_SILENCE] = 1'b0;
            if (hitMarker) ctrl_next[`RPSO_BIT_MARKER] = 1'b0;
            ctrl_next[`RPSO_BIT_SEEN] = 1'b1;
        end
    end

    // registers; a packet update wins over a bus write of the same word
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `RPSO_CTRL_RESET;
            target_reg <= `RPSO_DATA_RESET;
            remote_reg <= `RPSO_DATA_RESET;
            slip_reg <= `RPSO_DATA_RESET;
            local_reg <= `RPSO_DATA_RESET;
            minLead_reg <= `RPSO_DATA_RESET;
            initLead_reg <= `RPSO_DATA_RESET;
        end else begin
            if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_CTRL && !pktValid) begin
                ctrl_reg <= (ctrl_reg & ~byteMask) | (wb_dat_i & byteMask);
            end else begin
                ctrl_reg <= ctrl_next;
            end
            if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_TARGET) begin
                target_reg <= (target_reg & ~byteMask) | (wb_dat_i & byteMask);
            end
            if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_REMOTE && !pktValid) begin
                remote_reg <= (remote_reg & ~byteMask) | (wb_dat_i & byteMask);
            end else begin
                remote_reg <= remote_next;
            end
            if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_SLIP && !pktValid) begin
                slip_reg <= (slip_reg & ~byteMask) | (wb_dat_i & byteMask);
            end else begin
                slip_reg <= slip_next;
            end
            if (pktValid) begin
                local_reg <= localBusStamp;
            end else if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_LOCAL) begin
                local_reg <= (local_reg & ~byteMask) | (wb_dat_i & byteMask);
            end
            if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_MINLEAD) begin
                minLead_reg <= (minLead_reg & ~byteMask) | (wb_dat_i & byteMask);
            end
            if (wbReq && wb_we_i && wb_adr_i == `RPSO_ADR_INITLEAD) begin
                initLead_reg <= (initLead_reg & ~byteMask) | (wb_dat_i & byteMask);
            end
        end
    end

    // packet results, one cycle after the strobe
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            playDelta <= `RPSO_DATA_RESET;
            arrivalDelta <= `RPSO_DATA_RESET;
            pktDone <= 1'b0;
            slipEvent <= 1'b0;
        end else begin
            pktDone <= pktValid;
            slipEvent <= pktValid & (pktOverrun | pktUnderrun);
            if (pktValid) begin
                arrivalDelta <= pktRemoteStamp - localBusStamp;
                playDelta <= target_reg + slip_next;
            end
        end
    end

    // bus answer one cycle after the request, error on unmapped word
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= `RPSO_ERR_DATA;
        end else begin
            wb_ack_o <= wbReq & wbAddrOk;
            wb_err_o <= wbReq & ~wbAddrOk;
            wb_dat_o <= `RPSO_ERR_DATA;
            if (wbReq && !wb_we_i) begin
                case (wb_adr_i)
                    `RPSO_ADR_CTRL: wb_dat_o <= ctrl_reg;
                    `RPSO_ADR_TARGET: wb_dat_o <= target_reg;
                    `RPSO_ADR_REMOTE: wb_dat_o <= remote_reg;
                    `RPSO_ADR_SLIP: wb_dat_o <= slip_reg;
                    `RPSO_ADR_LOCAL: wb_dat_o <= local_reg;
                    `RPSO_ADR_MINLEAD: wb_dat_o <= minLead_reg;
                    `RPSO_ADR_INITLEAD: wb_dat_o <= initLead_reg;
                    default: wb_dat_o <= `RPSO_ERR_DATA;
                endcase
            end
        end
    end
endmodule // rpso_slip_ctrl

`default_nettype wire

// >>> rpso_pkt_src.sv
// Purpose: packet side model, one packet strobe per call
// Assumes: packets are one-cycle strobes on clk_sys
// Notes: stamps are inverted after each packet so stale values never match
`timescale 1ns/1ns
`default_nettype none
module rpso_pkt_src (
    input wire clk_sys,
    output logic pktValid,
    output logic pktRtp,
    output logic pktMarker,
    output logic [31:0] pktRemoteStamp,
    output logic [7:0] pktFrames,
    output logic [31:0] localBusStamp,
    output logic pktOverrun,
    output logic pktUnderrun,
    output logic [15:0] pktSlipFrames
);
    // quiet lines at time zero
    initial begin
        {pktValid, pktRtp, pktMarker, pktRemoteStamp, pktFrames} = '0;
        {localBusStamp, pktOverrun, pktUnderrun, pktSlipFrames} = '0;
    end
    // one strobe, then scramble the two stamps the packet carried
    task automatic send(input logic rtp, mk, input logic [31:0] rem, loc,
        input logic [7:0] fr, input logic ov, un, input logic [15:0] n);
        @(posedge clk_sys);
        pktValid <= 1'b1;
        {pktRtp, pktMarker, pktRemoteStamp, localBusStamp} <= {rtp, mk, rem, loc};
        {pktFrames, pktOverrun, pktUnderrun, pktSlipFrames} <= {fr, ov, un, n};
        @(posedge clk_sys);
        pktValid <= 1'b0;
        pktRemoteStamp <= ~rem;
        localBusStamp <= ~loc;
    endtask
endmodule // rpso_pkt_src
`default_nettype wire

// >>> rpso_slip_ctrl_assertions.sv
// Purpose: port checks for the slip offset block
// Assumes: one clock, asynchronous high reset
// Notes: bound to the block below
`timescale 1ns/1ns
`default_nettype none
module rpso_slip_ctrl_assertions (
    input wire clk_sys,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire pktValid,
    input wire pktOverrun,
    input wire pktUnderrun,
    input wire [31:0] pktRemoteStamp,
    input wire [31:0] localBusStamp,
    input wire [31:0] playDelta,
    input wire [31:0] arrivalDelta,
    input wire pktDone,
    input wire slipEvent
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // a request not yet answered
    wire fresh = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    // bus answers once, one cycle on
    bus_answer_time_a: assert property (fresh |=> wb_ack_o ^ wb_err_o)
        else $error("bus late");
    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    unmapped_err_a: assert property (fresh && wb_adr_i > 8'h18 |=> wb_err_o)
        else $error("no err");
    idle_dat_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("dat not zero");
    // packet results one cycle after the strobe, the two deltas held until the next
    done_after_pkt_a: assert property (pktValid |=> pktDone) else $error("no done");
    arrival_diff_a: assert property (pktValid |=>
        arrivalDelta == $past(pktRemoteStamp) - $past(localBusStamp)) else $error("diff");
    result_hold_a: assert property (!pktValid |=>
        $stable(playDelta) && $stable(arrivalDelta)) else $error("result moved");
    slip_flag_a: assert property (pktValid |-> ##1
        slipEvent == ($past(pktOverrun) || $past(pktUnderrun))) else $error("slip flag");
    cover property (pktValid && pktOverrun);
    cover property (pktValid && pktUnderrun);
    cover property (wb_err_o);
endmodule // rpso_slip_ctrl_assertions
bind rpso_slip_ctrl rpso_slip_ctrl_assertions chk (.clk_sys, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .pktValid, .pktOverrun,
    .pktUnderrun, .pktRemoteStamp, .localBusStamp, .playDelta, .arrivalDelta,
    .pktDone, .slipEvent);
`default_nettype wire

// >>> rpso_tb.sv
// Purpose: self-checking bench for the slip offset block
// Assumes: bench is the wishbone master, model drives packets
// Notes: slip, request, init and silence cases
`include "rpso_consts.vh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nErrors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
    logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, pktValid, pktRtp;
    logic pktMarker, pktOverrun, pktUnderrun, pktDone, slipEvent, gotErr;
    logic [7:0] wb_adr_i, pktFrames;
    logic [3:0] wb_sel_i;
    logic [15:0] pktSlipFrames;
    logic [31:0] wb_dat_i, wb_dat_o, pktRemoteStamp, localBusStamp, playDelta, arrivalDelta;
    logic [31:0] got, r;
    int nErrors, checksDone, cycCount;
    rpso_pkt_src src (.*);
    rpso_slip_ctrl dut (.*);
    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // hang guard, the run needs a few hundred cycles
    always @(posedge clk_sys) begin
        cycCount <= cycCount + 1;
        if (cycCount == 20000) begin
            nErrors++;
            finishTest();
        end
    end
    // one classic cycle, data taken at the ack edge
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_sys);
            t++;
        end while (!(wb_ack_o || wb_err_o) && t < 20);
        if (!(wb_ack_o || wb_err_o)) begin
            nErrors++;
            $display("ERROR bus answer expected 1 seen 0");
        end
        got = wb_dat_o;
        gotErr = wb_err_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        wbx(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, got)
    endtask
    // send one packet, then check slip, control and remote stamp
    task automatic pkt(input logic rtp, mk, input int gap, input logic [1:0] ou,
        input logic [15:0] n, s, c);
        r += gap;
        src.send(rtp, mk, rtp ? r : ~r, 32'h0000_0028, 8'h08, ou[1], ou[0], n);
        rd(`RPSO_ADR_SLIP, {{16{s[15]}}, s}, "slip");
        rd(`RPSO_ADR_CTRL, {16'h0000, c}, "ctrl");
        rd(`RPSO_ADR_REMOTE, r, "remote");
    endtask
    task automatic finishTest();
        $display("checks %0d errors %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        r = 32'h0000_003C;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`RPSO_ADR_CTRL, `RPSO_CTRL_RESET, "ctrl reset");
        wbx(1'b0, 8'h40, 32'h0000_0000);
        `CHK("err", 1'b1, gotErr)
        wbx(1'b1, `RPSO_ADR_TARGET, 32'h0000_0000);
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0000);
        pkt(1'b1, 1'b0, 40, 2'b10, 16'h0002, 16'h0002, 16'h0010);
        rd(`RPSO_ADR_LOCAL, 32'h0000_0028, "local");
        `CHK("arrival", 32'h0000_003C, arrivalDelta)
        wbx(1'b1, `RPSO_ADR_MINLEAD, 32'h0000_0005);
        wbx(1'b1, `RPSO_ADR_INITLEAD, 32'h0000_0003);
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0008);
        pkt(1'b1, 1'b0, 8, 2'b10, 16'h0004, 16'h0008, 16'h0018);
        $display("init test done");
        wbx(1'b1, `RPSO_ADR_TARGET, 32'h0000_0023);
        pkt(1'b1, 1'b0, 8, 2'b10, 16'h0003, 16'h000B, 16'h0018);
        `CHK("play", 32'h0000_002E, playDelta)
        pkt(1'b1, 1'b0, 8, 2'b01, 16'h0014, 16'hFFF7, 16'h0018);
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0070);
        pkt(1'b1, 1'b0, 8, 2'b10, 16'h0002, 16'hFFF7, 16'h0070);
        pkt(1'b1, 1'b0, 8, 2'b01, 16'h0002, 16'hFFF7, 16'h0070);
        pkt(1'b0, 1'b0, 8, 2'b00, 16'h0000, 16'hFFF7, 16'h0070);
        $display("slip test done");
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0011);
        pkt(1'b1, 1'b0, 8, 2'b10, 16'h0001, 16'h0000, 16'h0010);
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0014);
        pkt(1'b1, 1'b0, 8, 2'b10, 16'h0002, 16'h0002, 16'h0014);
        pkt(1'b1, 1'b1, 8, 2'b00, 16'h0000, 16'h0000, 16'h0010);
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0015);
        pkt(1'b1, 1'b1, 8, 2'b10, 16'h0001, 16'h0000, 16'h0010);
        wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0090);
        pkt(1'b1, 1'b0, 8, 2'b10, 16'h0003, 16'h0000, 16'h0090);
        `CHK("play", 32'h0000_0023, playDelta)
        $display("request test done");
        // one gap short of the threshold, then exactly on it
        for (int f = 0; f < 8; f++) begin
            wbx(1'b1, `RPSO_ADR_CTRL, 32'h0000_0012 | (f << 8));
            pkt(1'b1, 1'b0, (16 << f) - 1, 2'b10, 16'h0001, 16'h0001, 16'h0012 | (f << 8));
            pkt(1'b1, 1'b0, 16 << f, 2'b10, 16'h0001, 16'h0000, 16'h0010 | (f << 8));
        end
        $display("silence test done");
        finishTest();
    end
endmodule // tb
`default_nettype wire
